// ---- pkg/timer_pkg.sv ----
// constants, types and helpers shared by the dual 8-bit timer block
package timer_pkg;

    // register addresses in the register-addressing space
    localparam logic [7:0] ADDR_B_CNT  = 8'he6;
    localparam logic [7:0] ADDR_A_CNT  = 8'he7;
    localparam logic [7:0] ADDR_B_REF  = 8'he8;
    localparam logic [7:0] ADDR_A_REF  = 8'he9;
    localparam logic [7:0] ADDR_B_CTRL = 8'hea;
    localparam logic [7:0] ADDR_A_CTRL = 8'heb;

    // reset values
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] REF_RESET   = 8'hff;
    localparam logic [7:0] CNT_RESET   = 8'h00;
    localparam logic [7:0] READ_NONE   = 8'h00;

    // control field positions
    localparam int BIT_PEND   = 0;
    localparam int BIT_IE     = 1;
    localparam int BIT_EN     = 2;
    localparam int BIT_CLR    = 3;
    localparam int BIT_SEL_LO = 4;
    localparam int BIT_SEL_HI = 5;
    localparam int BIT_EXT    = 6;
    localparam int BIT_MODE16 = 7;

    // bits kept in storage; clear and pending are handled apart
    localparam logic [7:0] CTRL_A_WMASK = 8'hf6;
    localparam logic [7:0] CTRL_B_WMASK = 8'h36;

    // interrupt vectors on the shared level
    localparam logic [7:0] VEC_A = 8'he6;
    localparam logic [7:0] VEC_B = 8'he4;

    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        DIV256 = 2'h0,
        DIV64  = 2'h1,
        DIV8   = 2'h2,
        DIV1   = 2'h3
    } clk_div_t;

    // prescaler bits that must all be one for a tick
    function automatic logic [7:0] div_mask(input clk_div_t s);
        logic [7:0] m;
        m = 8'hff;
        case (s)
            DIV256:  m = 8'hff;
            DIV64:   m = 8'h3f;
            DIV8:    m = 8'h07;
            DIV1:    m = 8'h00;
            default: m = 8'hff;
        endcase
        return m;
    endfunction

endpackage

// ---- design/timer_tick_gen.sv ----
// prescaler and count-clock multiplexer for one timer
`timescale 1ns/1ns
module timer_tick_gen
#(
    parameter int DIV_W = 8
)
(
    input  wire logic              CLK,
    input  wire logic              SRST,
    input  wire timer_pkg::clk_div_t div_sel,
    input  wire logic              ext_sel,
    input  wire logic              ext_tick,
    output logic                   tick
);
    import timer_pkg::*;

    // refused at elaboration: the tick compare reads eight prescaler bits
    if (DIV_W < 8)
    begin
        $error("DIV_W must be at least 8");
    end

    logic [DIV_W-1:0] div_r;

    // free running, so a select change takes effect at once
    always_ff @(posedge CLK)
    begin
        if (SRST)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end

    always_comb
    begin
        if (ext_sel)
            tick = ext_tick;
        else
            tick = ((div_r[7:0] & div_mask(div_sel)) == div_mask(div_sel));
    end

endmodule

// ---- design/dual_interval_timers.sv ----
// dual 8-bit interval timers with optional 16-bit cascade
`timescale 1ns/1ns
module dual_interval_timers
(
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic       EXTERNAL_TIMER_CLOCK_IN,
    output logic            TIMER_A_MATCH_IRQ,
    output logic            TIMER_B_MATCH_IRQ,
    output logic            SHARED_INTERRUPT_LEVEL,
    output logic      [7:0] IRQ_VECTOR
);
    import timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl_a_r, ctrl_b_r, ref_a_r, ref_b_r, cnt_a_r, cnt_b_r;
    logic       pend_a_r, pend_b_r;
    logic       ext_s1_r, ext_s2_r, ext_s3_r;
    logic [7:0] rdata_nxt, vec_nxt;
    logic       wr_a, wr_b, clr_a, clr_b, clr_b_eff, mode16;
    logic       tick_a, tick_b, run_a, run_b, ext_edge;
    logic       match16, match_a, match_b, carry_a;

    ////////////////////////////////////////////////////////////////////////
    // pin passed through three stages; edge taken only from the settled second and third
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end
        else
        begin
            ext_s1_r <= EXTERNAL_TIMER_CLOCK_IN;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    assign ext_edge = ext_s2_r & ~ext_s3_r;

    timer_tick_gen #(.DIV_W(8)) u_tick_a
    (
        .CLK     (CLK),
        .SRST    (SRST),
        .div_sel (clk_div_t'(ctrl_a_r[BIT_SEL_HI:BIT_SEL_LO])),
        .ext_sel (ctrl_a_r[BIT_EXT]),
        .ext_tick(ext_edge),
        .tick    (tick_a)
    );

    timer_tick_gen #(.DIV_W(8)) u_tick_b
    (
        .CLK     (CLK),
        .SRST    (SRST),
        .div_sel (clk_div_t'(ctrl_b_r[BIT_SEL_HI:BIT_SEL_LO])),
        .ext_sel (1'b0),
        .ext_tick(1'b0),
        .tick    (tick_b)
    );

    ////////////////////////////////////////////////////////////////////////
    assign wr_a      = REG_WR && (REG_ADDR == ADDR_A_CTRL);
    assign wr_b      = REG_WR && (REG_ADDR == ADDR_B_CTRL);
    assign clr_a     = wr_a && REG_WDATA[BIT_CLR];
    assign clr_b     = wr_b && REG_WDATA[BIT_CLR];
    assign mode16    = ctrl_a_r[BIT_MODE16];
    // in cascade, timer A control owns both halves
    assign clr_b_eff = mode16 ? clr_a : clr_b;
    assign run_a     = tick_a && ctrl_a_r[BIT_EN];
    assign run_b     = tick_b && ctrl_b_r[BIT_EN] && !mode16;
    assign match16   = run_a && ({cnt_b_r, cnt_a_r} == {ref_b_r, ref_a_r});
    assign match_a   = mode16 ? match16 : (run_a && cnt_a_r == ref_a_r);
    assign match_b   = run_b && (cnt_b_r == ref_b_r);
    assign carry_a   = mode16 && run_a && (cnt_a_r == CNT_MAX) && !match16;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK)
    begin
        if (SRST)
            cnt_a_r <= CNT_RESET;
        else if (clr_a)
            cnt_a_r <= CNT_RESET;
        else if (match_a)
            cnt_a_r <= CNT_RESET;
        else if (run_a)
            cnt_a_r <= 8'(cnt_a_r + CNT_ONE);
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            cnt_b_r <= CNT_RESET;
        else if (clr_b_eff)
            cnt_b_r <= CNT_RESET;
        else if (match_b || (mode16 && match_a))
            cnt_b_r <= CNT_RESET;
        else if (carry_a || run_b)
            cnt_b_r <= 8'(cnt_b_r + CNT_ONE);
    end

    ////////////////////////////////////////////////////////////////////////
    // a match in the clearing cycle still sets the flag
    always_ff @(posedge CLK)
    begin
        if (SRST)
            pend_a_r <= 1'b0;
        else if (match_a)
            pend_a_r <= 1'b1;
        else if (wr_a && !REG_WDATA[BIT_PEND])
            pend_a_r <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
            pend_b_r <= 1'b0;
        else if (match_b)
            pend_b_r <= 1'b1;
        else if (wr_b && !REG_WDATA[BIT_PEND])
            pend_b_r <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ctrl_a_r <= CTRL_RESET;
            ctrl_b_r <= CTRL_RESET;
        end
        else
        begin
            if (wr_a)
                ctrl_a_r <= REG_WDATA & CTRL_A_WMASK;
            if (wr_b)
                ctrl_b_r <= REG_WDATA & CTRL_B_WMASK;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            ref_a_r <= REF_RESET;
            ref_b_r <= REF_RESET;
        end
        else
        begin
            if (REG_WR && REG_ADDR == ADDR_A_REF)
                ref_a_r <= REG_WDATA;
            if (REG_WR && REG_ADDR == ADDR_B_REF)
                ref_b_r <= REG_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        if (REG_ADDR == ADDR_A_CTRL)
            rdata_nxt = ctrl_a_r | {7'h00, pend_a_r};
        else if (REG_ADDR == ADDR_B_CTRL)
            rdata_nxt = ctrl_b_r | {7'h00, pend_b_r};
        else if (REG_ADDR == ADDR_A_REF)
            rdata_nxt = ref_a_r;
        else if (REG_ADDR == ADDR_B_REF)
            rdata_nxt = ref_b_r;
        else if (REG_ADDR == ADDR_A_CNT)
            rdata_nxt = cnt_a_r;
        else if (REG_ADDR == ADDR_B_CNT)
            rdata_nxt = cnt_b_r;
        else
            rdata_nxt = READ_NONE;
    end

    // timer A wins IRQ_VECTOR when both are raised
    assign TIMER_A_MATCH_IRQ = pend_a_r && ctrl_a_r[BIT_IE]
                               && ctrl_a_r[BIT_EN];
    assign TIMER_B_MATCH_IRQ = pend_b_r && ctrl_b_r[BIT_IE]
                               && ctrl_b_r[BIT_EN] && !mode16;
    assign SHARED_INTERRUPT_LEVEL = TIMER_A_MATCH_IRQ
                                    || TIMER_B_MATCH_IRQ;
    assign vec_nxt = TIMER_A_MATCH_IRQ ? VEC_A : VEC_B;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            REG_RDATA  <= READ_NONE;
            IRQ_VECTOR <= VEC_A;
        end
        else
        begin
            REG_RDATA  <= rdata_nxt;
            IRQ_VECTOR <= vec_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_ext_clock_tick: assert property (
        ctrl_a_r[BIT_EXT] |-> (tick_a == ext_edge))
        else $error("timer A tick does not follow external edge");

    a_b_div1_tick: assert property (
        ctrl_b_r[BIT_SEL_HI:BIT_SEL_LO] == DIV1 |-> tick_b)
        else $error("timer B missing tick at divide by one");

    a_b_match_wrap: assert property (
        match_b && !clr_b_eff |=> cnt_b_r == CNT_RESET && pend_b_r)
        else $error("timer B did not wrap on match");

    a_a_match_wrap: assert property (
        !mode16 && run_a && cnt_a_r == ref_a_r && !clr_a
        |=> cnt_a_r == CNT_RESET && pend_a_r)
        else $error("timer A did not wrap on match");

    a_b_count_step: assert property (
        run_b && cnt_b_r != ref_b_r && !clr_b_eff
        |=> cnt_b_r == $past(cnt_b_r) + CNT_ONE)
        else $error("timer B did not add one");

    a_pend_sticky: assert property (
        pend_a_r && !(wr_a && !REG_WDATA[BIT_PEND]) |=> pend_a_r)
        else $error("timer A pending dropped without software");

    a_pend_clear: assert property (
        wr_b && !REG_WDATA[BIT_PEND] && !match_b |=> !pend_b_r)
        else $error("timer B pending not cleared by write");

    a_clear_strobe: assert property (
        clr_a |=> cnt_a_r == CNT_RESET && !ctrl_a_r[BIT_CLR])
        else $error("clear strobe misbehaved");

    a_shared_vector: assert property (
        TIMER_B_MATCH_IRQ && !TIMER_A_MATCH_IRQ |=> IRQ_VECTOR == VEC_B)
        else $error("wrong vector for timer B");

    a_wide_carry: assert property (
        carry_a && !clr_b_eff |=> cnt_b_r == $past(cnt_b_r) + CNT_ONE)
        else $error("cascade carry lost");

    c_match_a:   cover property (match_a && !mode16);
    c_match_b:   cover property (match_b);
    c_match_16:  cover property (mode16 && match16);
    c_ext_count: cover property (ctrl_a_r[BIT_EXT] && run_a);

endmodule

// ---- testbench/dual_8bit_interval_timers_test.sv ----
// self-checking bench for the dual 8-bit interval timers
`timescale 1ns/1ns
module dual_8bit_interval_timers_test;
    import timer_pkg::*;

    logic       CLK;
    logic       SRST;
    logic [7:0] REG_ADDR;
    logic       REG_WR;
    logic [7:0] REG_WDATA;
    logic [7:0] REG_RDATA;
    logic       EXTERNAL_TIMER_CLOCK_IN;
    logic       TIMER_A_MATCH_IRQ;
    logic       TIMER_B_MATCH_IRQ;
    logic       SHARED_INTERRUPT_LEVEL;
    logic [7:0] IRQ_VECTOR;
    int         err_total;
    int         comparisons;

    dual_interval_timers dut
    (
        .CLK                     (CLK),
        .SRST                    (SRST),
        .REG_ADDR                (REG_ADDR),
        .REG_WR                  (REG_WR),
        .REG_WDATA               (REG_WDATA),
        .REG_RDATA               (REG_RDATA),
        .EXTERNAL_TIMER_CLOCK_IN (EXTERNAL_TIMER_CLOCK_IN),
        .TIMER_A_MATCH_IRQ       (TIMER_A_MATCH_IRQ),
        .TIMER_B_MATCH_IRQ       (TIMER_B_MATCH_IRQ),
        .SHARED_INTERRUPT_LEVEL  (SHARED_INTERRUPT_LEVEL),
        .IRQ_VECTOR              (IRQ_VECTOR)
    );

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // inputs move on the falling edge, away from the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        REG_ADDR  = a;
        REG_WDATA = d;
        REG_WR    = 1'b1;
        @(negedge CLK);
        REG_WR    = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        @(negedge CLK);
        d = REG_RDATA;
    endtask

    task automatic wait_hi(input bit b_side, input int bound);
        for (int i = 0; i < bound; i++)
        begin
            if ((b_side ? TIMER_B_MATCH_IRQ : TIMER_A_MATCH_IRQ) === 1'b1)
                return;
            @(negedge CLK);
        end
        $display("unexpected wait_irq expected 1 seen 0");
        err_total++;
        give_verdict;
    endtask

    task automatic ext_pulse;
        repeat (4) @(negedge CLK);
        EXTERNAL_TIMER_CLOCK_IN = 1'b1;
        repeat (4) @(negedge CLK);
        EXTERNAL_TIMER_CLOCK_IN = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        logic [7:0] ad [7] = '{8'he6, 8'he7, 8'he8, 8'he9,
                               8'hea, 8'heb, 8'h00};
        logic [7:0] ex [7] = '{8'h00, 8'h00, 8'hff, 8'hff,
                               8'h00, 8'h00, 8'h00};
        logic [7:0] d;
        check("irq_level", {15'h0, SHARED_INTERRUPT_LEVEL}, 16'h0);
        check("vector", {8'h0, IRQ_VECTOR}, {8'h0, VEC_A});
        for (int i = 0; i < 7; i++)
        begin
            rd(ad[i], d);
            check("reset_value", {8'h0, d}, {8'h0, ex[i]});
        end
        // counters are read only
        wr(ADDR_B_CNT, 8'h55);
        rd(ADDR_B_CNT, d);
        check("cnt_b_ro", {8'h0, d}, 16'h0);
        $display("test reset done");
    endtask

    // period (ref+1)*div measured between two matches on timer B
    task automatic test_divs;
        int         dv [4] = '{256, 64, 8, 1};
        logic [7:0] d;
        time        t0;
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_B_REF, 8'h10);
            wr(ADDR_B_CTRL, {2'b00, 2'(k), 4'he});
            wait_hi(1, 18 * 256);
            t0 = $time;
            check("shared", {15'h0, SHARED_INTERRUPT_LEVEL}, 16'h1);
            rd(ADDR_B_CTRL, d);
            check("ctrl_b_pend", {8'h0, d}, {10'h0, 2'(k), 4'h7});
            check("vector_b", {8'h0, IRQ_VECTOR}, {8'h0, VEC_B});
            wr(ADDR_B_CTRL, {2'b00, 2'(k), 4'h6});
            check("irq_b_clr", {15'h0, TIMER_B_MATCH_IRQ}, 16'h0);
            wait_hi(1, 18 * 256);
            check("period", 16'(($time - t0) / 20), 16'(17 * dv[k]));
        end
        $display("test divs done");
    endtask

    task automatic test_ext;
        logic [7:0] d;
        wr(ADDR_A_REF, 8'h02);
        wr(ADDR_A_CTRL, 8'h4e);
        ext_pulse();
        ext_pulse();
        repeat (6) @(negedge CLK);
        check("irq_a_early", {15'h0, TIMER_A_MATCH_IRQ}, 16'h0);
        rd(ADDR_A_CNT, d);
        check("cnt_a_ext", {8'h0, d}, 16'h2);
        ext_pulse();
        wait_hi(0, 10);
        @(negedge CLK);
        // timer B is still pending here, timer A takes the vector
        check("vector_a", {8'h0, IRQ_VECTOR}, {8'h0, VEC_A});
        rd(ADDR_A_CNT, d);
        check("cnt_a_wrap", {8'h0, d}, 16'h0);
        $display("test ext done");
    endtask

    task automatic test_clear;
        logic [7:0] d;
        wr(ADDR_B_REF, 8'hff);
        wr(ADDR_B_CTRL, 8'h34);
        repeat (40) @(negedge CLK);
        wr(ADDR_B_CTRL, 8'h3c);
        rd(ADDR_B_CNT, d);
        check("cnt_cleared", {15'h0, d < 8'h08}, 16'h1);
        repeat (20) @(negedge CLK);
        rd(ADDR_B_CNT, d);
        check("cnt_runs", {15'h0, d > 8'h08}, 16'h1);
        $display("test clear done");
    endtask

    task automatic test_mode16;
        logic [7:0] d;
        wr(ADDR_B_REF, 8'h01);
        wr(ADDR_B_CTRL, 8'h3e);
        wait_hi(1, 20);
        wr(ADDR_A_CTRL, 8'h80);
        check("irq_b_m16", {15'h0, TIMER_B_MATCH_IRQ}, 16'h0);
        rd(ADDR_A_CTRL, d);
        check("ctrl_a_m16", {8'h0, d}, 16'h80);
        // wide compare at 0101H: an 8-bit compare would fire after two ticks
        wr(ADDR_A_REF, 8'h01);
        wr(ADDR_A_CTRL, 8'hbe);
        repeat (250) @(negedge CLK);
        check("irq_a_m16_early", {15'h0, TIMER_A_MATCH_IRQ}, 16'h0);
        wait_hi(0, 20);
        check("irq_b_m16_hold", {15'h0, TIMER_B_MATCH_IRQ}, 16'h0);
        rd(ADDR_B_CNT, d);
        check("cnt_b_m16", {8'h0, d}, 16'h0);
        wr(ADDR_A_CTRL, 8'h00);
        check("irq_b_back", {15'h0, TIMER_B_MATCH_IRQ}, 16'h1);
        $display("test mode16 done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        err_total               = 0;
        comparisons             = 0;
        SRST                    = 1'b1;
        REG_ADDR                = 8'h00;
        REG_WR                  = 1'b0;
        REG_WDATA               = 8'h00;
        EXTERNAL_TIMER_CLOCK_IN = 1'b0;
        repeat (20) @(negedge CLK);
        SRST = 1'b0;
        test_reset();
        test_divs();
        test_ext();
        test_clear();
        test_mode16();
        give_verdict();
    end
endmodule
